// >>> include/csor_core_regs.vh
// register indices, field positions, reset values and operation codes of the core state block
`ifndef CSOR_CORE_REGS_VH
`define CSOR_CORE_REGS_VH

`define CSOR_AW              12
`define CSOR_IDX_IC          10'h004
`define CSOR_IDX_CMD         10'h008
`define CSOR_IDX_SP          10'h081
`define CSOR_IDX_PSW         10'h0d0
`define CSOR_IDX_ACC         10'h0e0
`define CSOR_IDX_B           10'h0f0

`define CSOR_IC_RST          16'h0000
`define CSOR_SP_RST          8'h07
`define CSOR_PSW_RST         8'h00
`define CSOR_ACC_RST         8'h00
`define CSOR_B_RST           8'h00

`define CSOR_PSW_CY          7
`define CSOR_PSW_AC          6
`define CSOR_PSW_F0          5
`define CSOR_PSW_RS1         4
`define CSOR_PSW_RS0         3
`define CSOR_PSW_OV          2
`define CSOR_PSW_F1          1
`define CSOR_PSW_P           0

`define CSOR_CMD_OP_LSB      0
`define CSOR_CMD_OP_MSB      3
`define CSOR_CMD_OPND_LSB    8
`define CSOR_CMD_OPND_MSB    15
`define CSOR_CMD_PEND_BIT    31

`define CSOR_OP_NONE         4'h0
`define CSOR_OP_ADD          4'h1
`define CSOR_OP_ADDC         4'h2
`define CSOR_OP_SUBB         4'h3
`define CSOR_OP_MUL          4'h4
`define CSOR_OP_DIV          4'h5
`define CSOR_OP_AND          4'h6
`define CSOR_OP_OR           4'h7
`define CSOR_OP_XOR          4'h8
`define CSOR_OP_MOV          4'h9

`define CSOR_RESP_OKAY       2'h0
`define CSOR_RESP_SLVERR     2'h2

`endif

// >>> core/csor_alu.v
// combinational arithmetic unit: add, subtract, product, quotient and logic ops
`timescale 1ns/1ns
`include "csor_core_regs.vh"
module csor_alu (
  op_code,
  acc_in,
  b_in,
  opnd_in,
  cy_in,
  acc_res,
  b_res,
  wr_acc,
  wr_b,
  cy_res,
  ac_res,
  ov_res,
  upd_cy,
  upd_ac,
  upd_ov
);
  input  wire [3:0] op_code;
  input  wire [7:0] acc_in;
  input  wire [7:0] b_in;
  input  wire [7:0] opnd_in;
  input  wire       cy_in;
  output reg  [7:0] acc_res;
  output reg  [7:0] b_res;
  output reg        wr_acc;
  output reg        wr_b;
  output reg        cy_res;
  output reg        ac_res;
  output reg        ov_res;
  output reg        upd_cy;
  output reg        upd_ac;
  output reg        upd_ov;

  reg        cin;
  reg [8:0]  sum9;
  reg [4:0]  nib5;
  reg [15:0] prod;

  always @* begin
    cin     = 1'b0;
    sum9    = 9'h000;
    nib5    = 5'h00;
    prod    = 16'h0000;
    acc_res = acc_in;
    b_res   = b_in;
    wr_acc  = 1'b0;
    wr_b    = 1'b0;
    cy_res  = cy_in;
    ac_res  = 1'b0;
    ov_res  = 1'b0;
    upd_cy  = 1'b0;
    upd_ac  = 1'b0;
    upd_ov  = 1'b0;
    case (op_code)
      `CSOR_OP_ADD, `CSOR_OP_ADDC: begin
        cin     = (op_code == `CSOR_OP_ADDC) ? cy_in : 1'b0;
        sum9    = {1'b0, acc_in} + {1'b0, opnd_in} + {8'h00, cin};
        nib5    = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, cin};
        acc_res = sum9[7:0];
        wr_acc  = 1'b1;
        cy_res  = sum9[8]; // [RULE7]
        ac_res  = nib5[4]; // [RULE8]
        ov_res  = (acc_in[7] == opnd_in[7]) && (sum9[7] != acc_in[7]); // [RULE11]
        upd_cy  = 1'b1;
        upd_ac  = 1'b1;
        upd_ov  = 1'b1;
      end
      `CSOR_OP_SUBB: begin
        sum9    = {1'b0, acc_in} - {1'b0, opnd_in} - {8'h00, cy_in};
        nib5    = {1'b0, acc_in[3:0]} - {1'b0, opnd_in[3:0]} - {4'h0, cy_in};
        acc_res = sum9[7:0];
        wr_acc  = 1'b1;
        cy_res  = sum9[8]; // [RULE7]
        ac_res  = nib5[4]; // [RULE8]
        ov_res  = (acc_in[7] != opnd_in[7]) && (sum9[7] != acc_in[7]); // [RULE11]
        upd_cy  = 1'b1;
        upd_ac  = 1'b1;
        upd_ov  = 1'b1;
      end
      `CSOR_OP_MUL: begin
        prod    = acc_in * b_in;
        acc_res = prod[7:0]; // [RULE3]
        b_res   = prod[15:8]; // [RULE3]
        wr_acc  = 1'b1;
        wr_b    = 1'b1;
        cy_res  = 1'b0;
        ov_res  = (prod[15:8] != 8'h00);
        upd_cy  = 1'b1;
        upd_ov  = 1'b1;
      end
      `CSOR_OP_DIV: begin
        // divide by zero leaves both operands alone and raises overflow
        cy_res = 1'b0;
        upd_cy = 1'b1;
        upd_ov = 1'b1;
        if (b_in == 8'h00) begin
          ov_res = 1'b1;
        end else begin
          acc_res = acc_in / b_in; // [RULE4]
          b_res   = acc_in % b_in; // [RULE4]
          wr_acc  = 1'b1;
          wr_b    = 1'b1;
        end
      end
      `CSOR_OP_AND: begin
        acc_res = acc_in & opnd_in; // [RULE2]
        wr_acc  = 1'b1;
      end
      `CSOR_OP_OR: begin
        acc_res = acc_in | opnd_in; // [RULE2]
        wr_acc  = 1'b1;
      end
      `CSOR_OP_XOR: begin
        acc_res = acc_in ^ opnd_in; // [RULE2]
        wr_acc  = 1'b1;
      end
      `CSOR_OP_MOV: begin
        acc_res = opnd_in; // [RULE2]
        wr_acc  = 1'b1;
      end
      default: begin
        wr_acc = 1'b0;
      end
    endcase
  end
endmodule

// >>> core/csor_top.v
// core architectural state: counter, operand registers, stack pointer, status word, axi4-lite
//
// Functional notes
// [RULE1] 16-bit instruction counter resets to zero
// [RULE2] main operand register sources and receives results
// [RULE3] product: low byte main, high byte second
// [RULE4] quotient to main, remainder to second
// [RULE5] second operand register freely read and written
// [RULE6] 8-bit stack pointer resets to 07h
// [RULE7] carry bit 7 tracks msb carry/borrow
// [RULE8] half-carry bit 6 tracks bit-3 carry/borrow
// [RULE9] bank select bits 4-3 pick ram bank
// [RULE10] parity bit 0 follows main operand register
// [RULE11] overflow bit 2; bits 5,1 user flags
`timescale 1ns/1ns
`include "csor_core_regs.vh"
module csor_top (
  mclk,
  sys_rst,
  s_axi_awaddr,
  s_axi_awprot,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arprot,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  seq_op_valid,
  seq_op_code,
  seq_operand,
  seq_pc_load,
  seq_pc_value,
  seq_pc_step,
  seq_sp_push,
  seq_sp_pop,
  instr_counter,
  main_operand,
  second_operand,
  stack_top_ptr,
  prog_status_word,
  bank_base,
  cmd_pending
);
  input  wire                 mclk;
  input  wire                 sys_rst;
  input  wire [`CSOR_AW-1:0]  s_axi_awaddr;
  input  wire [2:0]           s_axi_awprot;
  input  wire                 s_axi_awvalid;
  output wire                 s_axi_awready;
  input  wire [31:0]          s_axi_wdata;
  input  wire [3:0]           s_axi_wstrb;
  input  wire                 s_axi_wvalid;
  output wire                 s_axi_wready;
  output reg  [1:0]           s_axi_bresp;
  output reg                  s_axi_bvalid;
  input  wire                 s_axi_bready;
  input  wire [`CSOR_AW-1:0]  s_axi_araddr;
  input  wire [2:0]           s_axi_arprot;
  input  wire                 s_axi_arvalid;
  output wire                 s_axi_arready;
  output reg  [31:0]          s_axi_rdata;
  output reg  [1:0]           s_axi_rresp;
  output reg                  s_axi_rvalid;
  input  wire                 s_axi_rready;
  input  wire                 seq_op_valid;
  input  wire [3:0]           seq_op_code;
  input  wire [7:0]           seq_operand;
  input  wire                 seq_pc_load;
  input  wire [15:0]          seq_pc_value;
  input  wire                 seq_pc_step;
  input  wire                 seq_sp_push;
  input  wire                 seq_sp_pop;
  output wire [15:0]          instr_counter;
  output wire [7:0]           main_operand;
  output wire [7:0]           second_operand;
  output wire [7:0]           stack_top_ptr;
  output wire [7:0]           prog_status_word;
  output wire [7:0]           bank_base;
  output wire                 cmd_pending;

  // returns 1 when the word index names a register of this block
  function mapped;
    input [9:0] idx;
    begin
      case (idx)
        `CSOR_IDX_IC, `CSOR_IDX_CMD, `CSOR_IDX_SP,
        `CSOR_IDX_PSW, `CSOR_IDX_ACC, `CSOR_IDX_B: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [15:0]         ic_q;
  reg  [7:0]          acc_q;
  reg  [7:0]          b_q;
  reg  [7:0]          sp_q;
  reg  [7:0]          psw_q;
  reg                 cmd_pend_q;
  reg  [3:0]          cmd_op_q;
  reg  [7:0]          cmd_opnd_q;

  reg                 aw_held_q;
  reg  [9:0]          aw_idx_q;
  reg                 w_held_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;

  wire                parity;
  wire [7:0]          psw_view;
  wire                wr_fire;
  wire                wr_lane0;
  wire                rd_fire;
  wire [9:0]          rd_idx;
  reg  [31:0]         rd_word;

  wire                op_go;
  wire [3:0]          op_code;
  wire [7:0]          op_opnd;
  wire                cmd_go;
  wire [7:0]          alu_acc;
  wire [7:0]          alu_b;
  wire                alu_wr_acc;
  wire                alu_wr_b;
  wire                alu_cy;
  wire                alu_ac;
  wire                alu_ov;
  wire                alu_upd_cy;
  wire                alu_upd_ac;
  wire                alu_upd_ov;

  reg  [7:0]          acc_d;
  reg  [7:0]          b_d;
  reg  [7:0]          psw_d;
  reg  [7:0]          sp_d;
  reg  [15:0]         ic_d;

  // parity is never stored, so software cannot make it disagree with the operand
  assign parity   = ^acc_q; // [RULE10]
  assign psw_view = {psw_q[7:1], parity}; // [RULE10]

  // write address and data are held separately; either may arrive first
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb_q[0] && mapped(aw_idx_q);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[11:2];

  always @(posedge mclk) begin
    if (sys_rst) begin
      aw_held_q    <= 1'b0;
      aw_idx_q     <= 10'h000;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CSOR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_idx_q) ? `CSOR_RESP_OKAY : `CSOR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data is the state at the address handshake edge
  always @* begin
    rd_word = 32'h00000000;
    case (rd_idx)
      `CSOR_IDX_IC:  rd_word = {16'h0000, ic_q};
      `CSOR_IDX_CMD: rd_word = {cmd_pend_q, 15'h0000, cmd_opnd_q, 4'h0, cmd_op_q};
      `CSOR_IDX_SP:  rd_word = {24'h000000, sp_q};
      `CSOR_IDX_PSW: rd_word = {24'h000000, psw_view};
      `CSOR_IDX_ACC: rd_word = {24'h000000, acc_q};
      `CSOR_IDX_B:   rd_word = {24'h000000, b_q}; // [RULE5]
      default:       rd_word = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CSOR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(rd_idx) ? `CSOR_RESP_OKAY : `CSOR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // the sequencer owns the operation path; a software command waits behind it
  assign cmd_go  = cmd_pend_q && !seq_op_valid;
  assign op_go   = seq_op_valid || cmd_go;
  assign op_code = seq_op_valid ? seq_op_code : (cmd_go ? cmd_op_q : `CSOR_OP_NONE);
  assign op_opnd = seq_op_valid ? seq_operand : cmd_opnd_q;

  csor_alu u_alu (
    .op_code (op_code),
    .acc_in  (acc_q),
    .b_in    (b_q),
    .opnd_in (op_opnd),
    .cy_in   (psw_q[`CSOR_PSW_CY]),
    .acc_res (alu_acc),
    .b_res   (alu_b),
    .wr_acc  (alu_wr_acc),
    .wr_b    (alu_wr_b),
    .cy_res  (alu_cy),
    .ac_res  (alu_ac),
    .ov_res  (alu_ov),
    .upd_cy  (alu_upd_cy),
    .upd_ac  (alu_upd_ac),
    .upd_ov  (alu_upd_ov)
  );

  // an operation result beats a bus write to the same register in one cycle
  always @* begin
    acc_d = acc_q;
    if (op_go && alu_wr_acc) begin
      acc_d = alu_acc; // [RULE2]
    end else if (wr_lane0 && aw_idx_q == `CSOR_IDX_ACC) begin
      acc_d = w_data_q[7:0];
    end
  end

  always @* begin
    b_d = b_q;
    if (op_go && alu_wr_b) begin
      b_d = alu_b; // [RULE3]
    end else if (wr_lane0 && aw_idx_q == `CSOR_IDX_B) begin
      b_d = w_data_q[7:0]; // [RULE5]
    end
  end

  // bus writes bits 7..1; hardware flag updates override only the flags they touch
  always @* begin
    psw_d = psw_q;
    if (wr_lane0 && aw_idx_q == `CSOR_IDX_PSW) begin
      psw_d[7:1] = w_data_q[7:1]; // [RULE11]
    end
    if (op_go && alu_upd_cy) begin
      psw_d[`CSOR_PSW_CY] = alu_cy; // [RULE7]
    end
    if (op_go && alu_upd_ac) begin
      psw_d[`CSOR_PSW_AC] = alu_ac; // [RULE8]
    end
    if (op_go && alu_upd_ov) begin
      psw_d[`CSOR_PSW_OV] = alu_ov; // [RULE11]
    end
    psw_d[`CSOR_PSW_P] = 1'b0;
  end

  // stack grows upward: push pre-increments, pop post-decrements
  always @* begin
    sp_d = sp_q;
    if (seq_sp_push && !seq_sp_pop) begin
      sp_d = sp_q + 8'h01; // [RULE6]
    end else if (seq_sp_pop && !seq_sp_push) begin
      sp_d = sp_q - 8'h01; // [RULE6]
    end else if (wr_lane0 && aw_idx_q == `CSOR_IDX_SP) begin
      sp_d = w_data_q[7:0];
    end
  end

  always @* begin
    ic_d = ic_q;
    if (seq_pc_load) begin
      ic_d = seq_pc_value; // [RULE1]
    end else if (seq_pc_step) begin
      ic_d = ic_q + 16'h0001; // [RULE1]
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      ic_q  <= `CSOR_IC_RST; // [RULE1]
      acc_q <= `CSOR_ACC_RST;
      b_q   <= `CSOR_B_RST;
      sp_q  <= `CSOR_SP_RST; // [RULE6]
      psw_q <= `CSOR_PSW_RST;
    end else begin
      ic_q  <= ic_d;
      acc_q <= acc_d;
      b_q   <= b_d;
      sp_q  <= sp_d;
      psw_q <= psw_d;
    end
  end

  // a new command while one is pending replaces it; a set wins over the clear
  always @(posedge mclk) begin
    if (sys_rst) begin
      cmd_pend_q <= 1'b0;
      cmd_op_q   <= `CSOR_OP_NONE;
      cmd_opnd_q <= 8'h00;
    end else if (wr_lane0 && aw_idx_q == `CSOR_IDX_CMD) begin
      cmd_pend_q <= (w_data_q[`CSOR_CMD_OP_MSB:`CSOR_CMD_OP_LSB] != `CSOR_OP_NONE);
      cmd_op_q   <= w_data_q[`CSOR_CMD_OP_MSB:`CSOR_CMD_OP_LSB];
      if (w_strb_q[1]) begin
        cmd_opnd_q <= w_data_q[`CSOR_CMD_OPND_MSB:`CSOR_CMD_OPND_LSB];
      end
    end else if (cmd_go) begin
      cmd_pend_q <= 1'b0;
    end
  end

  assign instr_counter    = ic_q;
  assign main_operand     = acc_q;
  assign second_operand   = b_q;
  assign stack_top_ptr    = sp_q;
  assign prog_status_word = psw_view;
  // working registers sit at bank * 8 in internal ram
  assign bank_base        = {3'h0, psw_q[`CSOR_PSW_RS1], psw_q[`CSOR_PSW_RS0], 3'h0}; // [RULE9]
  assign cmd_pending      = cmd_pend_q;

endmodule

// >>> tb/csor_top_asserts.sv
// concurrent checks on the core state block ports
`timescale 1ns/1ns
`include "csor_core_regs.vh"
module csor_top_asserts (
  input wire        mclk,
  input wire        sys_rst,
  input wire        seq_op_valid,
  input wire [3:0]  seq_op_code,
  input wire [7:0]  seq_operand,
  input wire        seq_pc_load,
  input wire        seq_pc_step,
  input wire        seq_sp_push,
  input wire        seq_sp_pop,
  input wire [15:0] instr_counter,
  input wire [7:0]  main_operand,
  input wire [7:0]  second_operand,
  input wire [7:0]  stack_top_ptr,
  input wire [7:0]  prog_status_word,
  input wire [7:0]  bank_base,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready
);
  wire op_add = seq_op_valid && seq_op_code == `CSOR_OP_ADD;
  wire op_sub = seq_op_valid && seq_op_code == `CSOR_OP_SUBB;
  wire op_mul = seq_op_valid && seq_op_code == `CSOR_OP_MUL;
  // divide by zero leaves both registers alone, so it is kept out here
  wire op_div = seq_op_valid && seq_op_code == `CSOR_OP_DIV && second_operand != 8'h00;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  rst_state_a: assert property ($fell(sys_rst) |-> instr_counter == 16'h0000
    && stack_top_ptr == 8'h07 && prog_status_word == 8'h00) else $error("state not reset");
  pc_step_a: assert property (seq_pc_step && !seq_pc_load |=>
    instr_counter == $past(instr_counter) + 16'h0001) else $error("counter step wrong");
  add_sum_a: assert property (op_add |=> {prog_status_word[7], main_operand} ==
    {1'b0, $past(main_operand)} + {1'b0, $past(seq_operand)}) else $error("add wrong");
  half_carry_a: assert property (op_add |=> prog_status_word[6] ==
    ({1'b0, $past(main_operand[3:0])} + {1'b0, $past(seq_operand[3:0])} > 5'h0f))
    else $error("half carry wrong");
  sub_borrow_a: assert property (op_sub |=> prog_status_word[7] ==
    ({1'b0, $past(main_operand)} < {1'b0, $past(seq_operand)} + {8'h00,
    $past(prog_status_word[7])})) else $error("borrow wrong");
  add_ovf_a: assert property (op_add |=> prog_status_word[2] ==
    ($past(main_operand[7]) == $past(seq_operand[7]) && main_operand[7] !=
    $past(main_operand[7]))) else $error("overflow wrong");
  mul_res_a: assert property (op_mul |=> {second_operand, main_operand} ==
    $past(main_operand) * $past(second_operand)) else $error("product wrong");
  div_res_a: assert property (op_div |=>
    main_operand == $past(main_operand) / $past(second_operand) &&
    second_operand == $past(main_operand) % $past(second_operand)) else $error("quotient wrong");
  push_sp_a: assert property (seq_sp_push && !seq_sp_pop |=>
    stack_top_ptr == $past(stack_top_ptr) + 8'h01) else $error("push wrong");
  pop_sp_a: assert property (seq_sp_pop && !seq_sp_push |=>
    stack_top_ptr == $past(stack_top_ptr) - 8'h01) else $error("pop wrong");
  parity_a: assert property (prog_status_word[0] == ^main_operand)
    else $error("parity wrong");
  bank_map_a: assert property (bank_base == {3'b000, prog_status_word[4:3], 3'b000})
    else $error("bank base wrong");
  mul_c: cover property (op_mul);
  div_c: cover property (op_div);
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind csor_top csor_top_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .seq_op_valid(seq_op_valid), .seq_op_code(seq_op_code), .seq_operand(seq_operand),
  .seq_pc_load(seq_pc_load), .seq_pc_step(seq_pc_step), .seq_sp_push(seq_sp_push),
  .seq_sp_pop(seq_sp_pop), .instr_counter(instr_counter), .main_operand(main_operand),
  .second_operand(second_operand), .stack_top_ptr(stack_top_ptr),
  .prog_status_word(prog_status_word), .bank_base(bank_base),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// >>> tb/tb_csor_top.sv
// self-checking bench for the core state block
`timescale 1ns/1ns
`include "csor_core_regs.vh"
module tb_csor_top;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        op_v = 1'b0, pc_ld = 1'b0, pc_st = 1'b0, push = 1'b0, pop = 1'b0;
  logic [3:0]  op_c = 4'h0;
  logic [7:0]  opnd = 8'h00;
  logic [15:0] pc_val = 16'h0000;
  wire         awready, wready, bvalid, arready, rvalid, pend;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [15:0]  ic;
  wire [7:0]   acc, bq, sp, prog_status_word_reg, bank;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;

  csor_top u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .seq_op_valid(op_v), .seq_op_code(op_c),
    .seq_operand(opnd), .seq_pc_load(pc_ld), .seq_pc_value(pc_val), .seq_pc_step(pc_st),
    .seq_sp_push(push), .seq_sp_pop(pop), .instr_counter(ic), .main_operand(acc),
    .second_operand(bq), .stack_top_ptr(sp), .prog_status_word(prog_status_word_reg), .bank_base(bank),
    .cmd_pending(pend)
  );

  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a hung handshake ends here; the ceiling is far above the few hundred cycles used
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic a, w;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    awprot <= idx[2:0];
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    while (!(a && w)) begin
      @(posedge mclk);
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    chk(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arprot <= idx[2:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk(rresp, er);
    rready <= 1'b0;
  endtask

  task automatic op(input logic [3:0] c, input logic [7:0] v);
    @(posedge mclk);
    op_c <= c;
    opnd <= v;
    op_v <= 1'b1;
    @(posedge mclk);
    op_v <= 1'b0;
    #1;
  endtask

  // expected flags are carry, half carry, overflow; parity comes from the expected value
  task automatic ochk(input logic [3:0] c, input logic [7:0] v, input logic [7:0] ea,
                      input logic [2:0] ef);
    op(c, v);
    chk({acc, prog_status_word_reg[7], prog_status_word_reg[6], prog_status_word_reg[2], prog_status_word_reg[0]}, {ea, ef, ^ea});
  endtask

  task automatic mchk(input logic [3:0] c, input logic [7:0] ea, input logic [7:0] eb,
                      input logic [1:0] ef);
    op(c, 8'h00);
    chk({acc, bq, prog_status_word_reg[7], prog_status_word_reg[2]}, {ea, eb, ef});
  endtask

  task automatic t_reset;
    rd(`CSOR_IDX_IC, 32'h0, 2'h0);
    rd(`CSOR_IDX_SP, 32'h7, 2'h0);
    rd(`CSOR_IDX_PSW, 32'h0, 2'h0);
    rd(`CSOR_IDX_ACC, 32'h0, 2'h0);
    rd(`CSOR_IDX_B, 32'h0, 2'h0);
    // the counter belongs to the sequencer; a bus write must not move it
    wr(`CSOR_IDX_IC, 32'h1234, 2'h0);
    rd(`CSOR_IDX_IC, 32'h0, 2'h0);
  endtask

  task automatic t_regs;
    wr(`CSOR_IDX_B, 32'ha5, 2'h0);
    wstrb <= 4'he;
    wr(`CSOR_IDX_B, 32'h11, 2'h0);
    wstrb <= 4'hf;
    rd(`CSOR_IDX_B, 32'ha5, 2'h0);
    wr(`CSOR_IDX_SP, 32'h3c, 2'h0);
    rd(`CSOR_IDX_SP, 32'h3c, 2'h0);
    wr(`CSOR_IDX_ACC, 32'h5c, 2'h0);
    rd(`CSOR_IDX_ACC, 32'h5c, 2'h0);
    op(`CSOR_OP_MOV, 8'h01);
    wr(`CSOR_IDX_PSW, 32'hfe, 2'h0);
    rd(`CSOR_IDX_PSW, 32'hff, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`CSOR_IDX_PSW, {27'h0, i[1:0], 3'h0}, 2'h0);
      chk(bank, {3'h0, i[1:0], 3'h0});
      rd(`CSOR_IDX_PSW, {27'h0, i[1:0], 3'h1}, 2'h0);
    end
    wr(10'h3ff, 32'h1, 2'h2);
    rd(10'h3ff, 32'h0, 2'h2);
  endtask

  task automatic t_alu;
    wr(`CSOR_IDX_PSW, 32'h0, 2'h0);
    ochk(`CSOR_OP_MOV, 8'h7f, 8'h7f, 3'b000);
    ochk(`CSOR_OP_ADD, 8'h01, 8'h80, 3'b011);
    ochk(`CSOR_OP_ADD, 8'h80, 8'h00, 3'b101);
    ochk(`CSOR_OP_ADDC, 8'h0e, 8'h0f, 3'b000);
    ochk(`CSOR_OP_SUBB, 8'h10, 8'hff, 3'b100);
    ochk(`CSOR_OP_SUBB, 8'h7f, 8'h7f, 3'b011);
    ochk(`CSOR_OP_AND, 8'h3c, 8'h3c, 3'b011);
    ochk(`CSOR_OP_OR, 8'hc1, 8'hfd, 3'b011);
    ochk(`CSOR_OP_XOR, 8'hff, 8'h02, 3'b011);
    wr(`CSOR_IDX_PSW, 32'h22, 2'h0);
    ochk(`CSOR_OP_ADD, 8'h00, 8'h02, 3'b000);
    rd(`CSOR_IDX_PSW, 32'h23, 2'h0);
  endtask

  task automatic t_muldiv;
    op(`CSOR_OP_MOV, 8'hf0);
    wr(`CSOR_IDX_B, 32'h20, 2'h0);
    mchk(`CSOR_OP_MUL, 8'h00, 8'h1e, 2'b01);
    mchk(`CSOR_OP_MUL, 8'h00, 8'h00, 2'b00);
    op(`CSOR_OP_MOV, 8'hff);
    wr(`CSOR_IDX_B, 32'hff, 2'h0);
    mchk(`CSOR_OP_MUL, 8'h01, 8'hfe, 2'b01);
    op(`CSOR_OP_MOV, 8'hc8);
    wr(`CSOR_IDX_B, 32'h0d, 2'h0);
    mchk(`CSOR_OP_DIV, 8'h0f, 8'h05, 2'b00);
    wr(`CSOR_IDX_B, 32'h00, 2'h0);
    mchk(`CSOR_OP_DIV, 8'h0f, 8'h00, 2'b01);
  endtask

  task automatic t_cmd;
    wr(`CSOR_IDX_CMD, {16'h0, 8'h4b, 4'h0, `CSOR_OP_ADD}, 2'h0);
    do @(posedge mclk); while (pend !== 1'b0);
    #1;
    chk({acc, prog_status_word_reg[7], prog_status_word_reg[6]}, {8'h5a, 2'b01});
    rd(`CSOR_IDX_ACC, 32'h5a, 2'h0);
    // a no-op from the sequencer keeps the path, so the command stays pending
    op_c <= `CSOR_OP_NONE;
    op_v <= 1'b1;
    wr(`CSOR_IDX_CMD, {16'h0, 8'h11, 4'h0, `CSOR_OP_XOR}, 2'h0);
    rd(`CSOR_IDX_CMD, 32'h80001108, 2'h0);
    chk(acc, 8'h5a);
    // writing op code zero cancels it before the path frees up
    wr(`CSOR_IDX_CMD, 32'h0, 2'h0);
    op_v <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({acc, 7'h00, pend}, {8'h5a, 8'h00});
  endtask

  task automatic t_pcsp;
    @(posedge mclk);
    pc_val <= 16'hfffe;
    pc_ld <= 1'b1;
    pc_st <= 1'b1;
    @(posedge mclk);
    pc_ld <= 1'b0;
    @(posedge mclk);
    pc_st <= 1'b0;
    push <= 1'b1;
    repeat (2) @(posedge mclk);
    push <= 1'b0;
    pop <= 1'b1;
    @(posedge mclk);
    pop <= 1'b0;
    #1;
    chk({ic, sp}, {16'hffff, 8'h3d});
    rd(`CSOR_IDX_IC, 32'hffff, 2'h0);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({ic, sp, acc}, {16'h0000, 8'h07, 8'h00});
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_alu();
    t_muldiv();
    t_cmd();
    t_pcsp();
    close_out();
  end
endmodule
